// ### hw/dckm_dual_clock_checker.sv
// dual clock checker: ratio measurement of two selected clocks
// Functional notes
// - first source select, four bits, reserved silent
// - second source select, five bits, reserved silent
// - compare both counts for fixed ratio
// - tolerance window in reference clock cycles
// - continuous mode restarts itself after each pass, holds after a fail until start
// - single mode measures once, then holds
`timescale 1ns/1ns
`default_nettype none
`include "dckm_cfg.svh"
module dckm_dual_clock_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // monitored clocks, indexed by select code
  input wire logic [`DCKM_SRC0_N-1:0] i_first_clocks,
  input wire logic [`DCKM_SRC1_N-1:0] i_second_clocks,
  // configuration
  input wire logic [`DCKM_SEL0_W-1:0] i_first_counter_source_select,
  input wire logic [`DCKM_SEL1_W-1:0] i_second_counter_source_select,
  input wire logic [`DCKM_SEED_W-1:0] i_ref_seed,
  input wire logic [`DCKM_TOL_W-1:0] i_tol_window,
  input wire logic [`DCKM_SEED_W-1:0] i_test_seed,
  input wire logic i_enable,
  input wire logic i_single_mode,
  // control strobes
  input wire logic i_start,
  input wire logic i_clear_flags,
  // status
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic o_error_event,
  output logic [`DCKM_CNT_W-1:0] o_ref_count,
  output logic [`DCKM_CNT_W-1:0] o_test_count
);
  dckm_edge_if edges ();
  dckm_src_tap u_tap (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_first_clocks(i_first_clocks),
    .i_second_clocks(i_second_clocks),
    .i_first_counter_source_select(i_first_counter_source_select),
    .i_second_counter_source_select(i_second_counter_source_select),
    .o_edges(edges.src)
  );
  dckm_pkg::dckm_state_e state_q, state_d;
  logic [`DCKM_CNT_W-1:0] rc_q, rc_d, tc_q, tc_d, rc_nx, tc_nx, load_rc, load_tc, tol_w;
  logic busy_q, busy_d, done_q, done_d, err_q, err_d, evt_q, evt_d;
  logic codes_ok, pass, fail, load;
  always_comb begin
    codes_ok = edges.ref_ok & edges.test_ok;
    tol_w = {{(`DCKM_CNT_W-`DCKM_TOL_W){1'b0}}, i_tol_window};
    // reference counts seed plus window, so the window is its last stretch
    load_rc = {1'b0, i_ref_seed} + tol_w;
    load_tc = {1'b0, i_test_seed};
    rc_nx = rc_q - {{(`DCKM_CNT_W-1){1'b0}}, (edges.ref_edge && rc_q != '0)};
    tc_nx = tc_q - {{(`DCKM_CNT_W-1){1'b0}}, (edges.test_edge && tc_q != '0)};
    // test count ends while reference sits in the window
    pass = (tc_q != '0) && (tc_nx == '0) && (rc_nx <= tol_w);
    fail = ((tc_q != '0) && (tc_nx == '0) && (rc_nx > tol_w)) ||
      ((rc_nx == '0) && ((tc_nx != '0) || (tc_q == '0)));
    load = 1'b0;
    state_d = state_q;
    rc_d = rc_q;
    tc_d = tc_q;
    evt_d = 1'b0;
    // a new result wins over a clear in the same cycle
    done_d = done_q & ~i_clear_flags;
    err_d = err_q & ~i_clear_flags;
    unique case (state_q)
      dckm_pkg::ST_IDLE: begin
        load = i_enable & codes_ok & (~i_single_mode | i_start);
      end
      dckm_pkg::ST_RUN: begin
        rc_d = rc_nx;
        tc_d = tc_nx;
        if (!i_enable || !codes_ok) begin
          state_d = dckm_pkg::ST_IDLE;
        end else if (fail) begin
          err_d = 1'b1;
          evt_d = 1'b1;
          state_d = dckm_pkg::ST_HOLD;
        end else if (pass) begin
          done_d = 1'b1;
          if (i_single_mode) begin
            state_d = dckm_pkg::ST_HOLD;
          end else begin
            load = 1'b1;
          end
        end
      end
      dckm_pkg::ST_HOLD: begin
        // result counts stay visible until software starts again
        if (!i_enable) begin
          state_d = dckm_pkg::ST_IDLE;
        end else begin
          load = i_start & codes_ok;
        end
      end
    endcase
    if (load) begin
      rc_d = load_rc;
      tc_d = load_tc;
      state_d = dckm_pkg::ST_RUN;
    end
    busy_d = (state_d == dckm_pkg::ST_RUN);
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= dckm_pkg::ST_IDLE;
      rc_q <= `DCKM_CNT_RST;
      tc_q <= `DCKM_CNT_RST;
      busy_q <= `DCKM_FLAG_RST;
      done_q <= `DCKM_FLAG_RST;
      err_q <= `DCKM_FLAG_RST;
      evt_q <= `DCKM_FLAG_RST;
    end else begin
      state_q <= state_d;
      rc_q <= rc_d;
      tc_q <= tc_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
      evt_q <= evt_d;
    end
  end
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_error = err_q;
  assign o_error_event = evt_q;
  assign o_ref_count = rc_q;
  assign o_test_count = tc_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_PASS_SETS_DONE: assert property (
    state_q == dckm_pkg::ST_RUN && i_enable && codes_ok && pass && !fail |=> o_done)
    else $error("pass without done");
  AST_WINDOW_JUDGED: assert property ($rose(o_done) |-> $past(rc_nx) <= $past(tol_w))
    else $error("done outside tolerance window");
  AST_CONT_RESTART: assert property (
    state_q == dckm_pkg::ST_RUN && i_enable && codes_ok && pass && !fail && !i_single_mode
    |=> o_busy && tc_q == $past(load_tc))
    else $error("continuous mode did not restart");
  AST_SINGLE_STOPS: assert property (
    state_q == dckm_pkg::ST_RUN && i_enable && codes_ok && pass && !fail && i_single_mode
    |=> !o_busy ##1 (!o_busy || $past(i_start)))
    else $error("single mode kept running");
  AST_HOLD_KEEPS: assert property (state_q == dckm_pkg::ST_HOLD && !i_start
    |=> $stable(o_ref_count) && $stable(o_test_count))
    else $error("held result changed");
  AST_ERR_EVENT: assert property (o_error_event |-> o_error ##1 !o_error_event)
    else $error("error event not paired with sticky flag");
  AST_ERR_STICKY: assert property (o_error && !i_clear_flags |=> o_error)
    else $error("error flag dropped without clear");
  AST_FAIL_RAISES: assert property (
    state_q == dckm_pkg::ST_RUN && i_enable && codes_ok && fail
    |=> o_error && o_error_event && !o_busy)
    else $error("failure not flagged");

  // starting, reserved codes and enable
  AST_RESERVED_NO_LOAD: assert property (
    state_q == dckm_pkg::ST_IDLE && !codes_ok |=> !o_busy)
    else $error("load with a reserved source code");
  AST_RESERVED_ABORTS: assert property (
    state_q == dckm_pkg::ST_RUN && !codes_ok |=> !o_busy && !o_error_event)
    else $error("reserved source code did not abort quietly");
  AST_SINGLE_WAITS_START: assert property (
    state_q == dckm_pkg::ST_IDLE && i_single_mode && !i_start |=> !o_busy)
    else $error("single mode started without a strobe");
  AST_CONT_SELF_START: assert property (
    state_q == dckm_pkg::ST_IDLE && i_enable && codes_ok && !i_single_mode |=> o_busy)
    else $error("continuous mode did not start by itself");
  AST_DISABLE_STOPS: assert property (!i_enable |=> !o_busy)
    else $error("measurement ran while disabled");

  // seeds and counting
  AST_REF_SEEDED: assert property ($rose(o_busy) |-> o_ref_count == $past(load_rc))
    else $error("reference count not seeded with seed plus window");
  AST_TEST_SEEDED: assert property ($rose(o_busy) |-> o_test_count == $past(load_tc))
    else $error("test count not seeded");
  AST_COUNT_STEPS: assert property (
    state_q == dckm_pkg::ST_RUN && i_enable && codes_ok && !pass && !fail
    |=> o_ref_count == $past(rc_nx) && o_test_count == $past(tc_nx))
    else $error("counts did not follow the edges");
  AST_REF_NEEDS_EDGE: assert property (
    state_q == dckm_pkg::ST_RUN && !edges.ref_edge && !pass && !fail
    |=> $stable(o_ref_count))
    else $error("reference count moved without an edge");
  AST_TEST_NEEDS_EDGE: assert property (
    state_q == dckm_pkg::ST_RUN && !edges.test_edge && !pass && !fail
    |=> $stable(o_test_count))
    else $error("test count moved without an edge");
  AST_START_IGNORED: assert property (
    state_q == dckm_pkg::ST_RUN && i_start && !pass && !fail
    |=> o_test_count == $past(tc_nx))
    else $error("start strobe disturbed a running measurement");
  AST_SINGLE_NO_RELOAD: assert property (
    state_q == dckm_pkg::ST_RUN && i_enable && codes_ok && pass && !fail && i_single_mode
    |=> o_test_count == $past(tc_nx))
    else $error("single mode reloaded its counts");

  // flags
  AST_DONE_STICKY: assert property (o_done && !i_clear_flags |=> o_done)
    else $error("done flag dropped without clear");
  AST_CLEAR_WORKS: assert property (
    i_clear_flags && state_q != dckm_pkg::ST_RUN |=> !o_done && !o_error)
    else $error("clear left a flag standing");
  AST_ERR_HAS_EVENT: assert property ($rose(o_error) |-> o_error_event)
    else $error("error flag rose without its event");
  AST_DONE_FROM_RUN: assert property ($rose(o_done) |-> $past(o_busy))
    else $error("done rose outside a measurement");
  AST_ERR_FROM_RUN: assert property ($rose(o_error) |-> $past(o_busy))
    else $error("error rose outside a measurement");
  AST_HOLD_QUIET: assert property (
    state_q == dckm_pkg::ST_HOLD |=> !o_error_event && !$rose(o_done))
    else $error("held result produced a new flag");

  COV_PASS: cover property ($rose(o_done));
  COV_FAIL: cover property (o_error_event);
  COV_CONT_TWO: cover property (o_done && o_busy ##[1:1000] $rose(o_busy));
  COV_SINGLE_HOLD: cover property (state_q == dckm_pkg::ST_HOLD && o_done);
  COV_RESERVED_ABORT: cover property (state_q == dckm_pkg::ST_RUN && !codes_ok);
endmodule
`default_nettype wire

// ### hw/dckm_src_tap.sv
// source synchronisers, selection and rising edge pulses
`timescale 1ns/1ns
`default_nettype none
`include "dckm_cfg.svh"
module dckm_src_tap (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // raw clocks and selects
  input wire logic [`DCKM_SRC0_N-1:0] i_first_clocks,
  input wire logic [`DCKM_SRC1_N-1:0] i_second_clocks,
  input wire logic [`DCKM_SEL0_W-1:0] i_first_counter_source_select,
  input wire logic [`DCKM_SEL1_W-1:0] i_second_counter_source_select,
  // edges out
  dckm_edge_if.src o_edges
);
  localparam logic [`DCKM_SRC0_N-1:0] MAP0 = `DCKM_SRC0_MAP;
  localparam logic [`DCKM_SRC1_N-1:0] MAP1 = `DCKM_SRC1_MAP;
  logic [`DCKM_SRC0_N-1:0] s0a_q, s0b_q, s0a_d, s0b_d;
  logic [`DCKM_SRC1_N-1:0] s1a_q, s1b_q, s1a_d, s1b_d;
  logic ref_prev_q, test_prev_q, ref_prev_d, test_prev_d;
  logic ref_lvl, test_lvl;
  // reserved codes carry no clock, their flops stay at zero
  genvar gi;
  generate
    for (gi = 0; gi < `DCKM_SRC0_N; gi++) begin : g_s0
      assign s0a_d[gi] = MAP0[gi] & i_first_clocks[gi];
      assign s0b_d[gi] = s0a_q[gi];
    end
    for (gi = 0; gi < `DCKM_SRC1_N; gi++) begin : g_s1
      assign s1a_d[gi] = MAP1[gi] & i_second_clocks[gi];
      assign s1b_d[gi] = s1a_q[gi];
    end
  endgenerate
  always_comb begin
    ref_lvl = s0b_q[i_first_counter_source_select];
    test_lvl = s1b_q[i_second_counter_source_select];
    ref_prev_d = ref_lvl;
    test_prev_d = test_lvl;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s0a_q <= '0;
      s0b_q <= '0;
      s1a_q <= '0;
      s1b_q <= '0;
      ref_prev_q <= 1'b0;
      test_prev_q <= 1'b0;
    end else begin
      s0a_q <= s0a_d;
      s0b_q <= s0b_d;
      s1a_q <= s1a_d;
      s1b_q <= s1b_d;
      ref_prev_q <= ref_prev_d;
      test_prev_q <= test_prev_d;
    end
  end
  // sources must run below half of i_clk or edges are lost
  assign o_edges.ref_edge = ref_lvl & ~ref_prev_q;
  assign o_edges.test_edge = test_lvl & ~test_prev_q;
  assign o_edges.ref_ok = MAP0[i_first_counter_source_select];
  assign o_edges.test_ok = MAP1[i_second_counter_source_select];
  AST_REF_RESERVED_SILENT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !MAP0[i_first_counter_source_select] |-> !o_edges.ref_edge)
    else $error("edge seen on reserved first source");
  AST_TEST_RESERVED_SILENT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !MAP1[i_second_counter_source_select] |-> !o_edges.test_edge)
    else $error("edge seen on reserved second source");
endmodule
`default_nettype wire

// ### inc/dckm_cfg.svh
// constants for the dual clock checker
`ifndef DCKM_CFG_SVH
`define DCKM_CFG_SVH
`define DCKM_SEL0_W 4
`define DCKM_SEL1_W 5
`define DCKM_SRC0_N 16
`define DCKM_SRC1_N 32
`define DCKM_CNT_W 21
`define DCKM_SEED_W 20
`define DCKM_TOL_W 16
// codes with a clock behind them, one bit per code
`define DCKM_SRC0_MAP 16'h1137
`define DCKM_SRC1_MAP 32'h0000FE4D
// first counter codes
`define DCKM_S0_CRYSTAL 4'h0
`define DCKM_S0_OSC_ONE 4'h1
`define DCKM_S0_OSC_TWO 4'h2
`define DCKM_S0_TEST_CLK 4'h4
`define DCKM_S0_CORE_SYS 4'h5
`define DCKM_S0_AUX_IN 4'h8
`define DCKM_S0_XBAR16 4'hC
// second counter codes
`define DCKM_S1_RAW_PLL 5'h00
`define DCKM_S1_OSC_ONE 5'h02
`define DCKM_S1_OSC_TWO 5'h03
`define DCKM_S1_CORE_SYS 5'h06
`define DCKM_S1_XBAR15 5'h09
`define DCKM_S1_AUX_IN 5'h0A
`define DCKM_S1_PWM 5'h0B
`define DCKM_S1_LOW_SPEED 5'h0C
`define DCKM_S1_CONVERTER 5'h0D
`define DCKM_S1_WATCHDOG 5'h0E
`define DCKM_S1_CAN_BIT 5'h0F
// reset values
`define DCKM_CNT_RST 21'h000000
`define DCKM_FLAG_RST 1'b0
`endif

// ### inc/dckm_edge_if.sv
// edge pulses from the source tap to the checker
`timescale 1ns/1ns
`default_nettype none
interface dckm_edge_if;
  logic ref_edge;
  logic test_edge;
  logic ref_ok;
  logic test_ok;
  modport src (output ref_edge, output test_edge, output ref_ok, output test_ok);
  modport chk (input ref_edge, input test_edge, input ref_ok, input test_ok);
endinterface
`default_nettype wire

// ### inc/dckm_pkg.sv
// types for the dual clock checker
package dckm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } dckm_state_e;
endpackage

// ### testbench/tb_dckm_dual_clock_checker.sv
// self-checking bench for the dual clock checker
`timescale 1ns/1ns
`default_nettype none
`include "dckm_cfg.svh"
module tb_dckm_dual_clock_checker;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic slow_clk = 1'b0;
  wire logic [`DCKM_SRC0_N-1:0] i_first_clocks;
  wire logic [`DCKM_SRC1_N-1:0] i_second_clocks;
  logic [`DCKM_SEL0_W-1:0] i_first_counter_source_select = '0;
  logic [`DCKM_SEL1_W-1:0] i_second_counter_source_select = '0;
  logic [`DCKM_SEED_W-1:0] i_ref_seed = 20'h00008;
  logic [`DCKM_TOL_W-1:0] i_tol_window = 16'h0002;
  logic [`DCKM_SEED_W-1:0] i_test_seed = 20'h00008;
  logic i_enable = 1'b0;
  logic i_single_mode = 1'b0;
  logic i_start = 1'b0;
  logic i_clear_flags = 1'b0;
  logic o_busy, o_done, o_error, o_error_event;
  logic [`DCKM_CNT_W-1:0] o_ref_count, o_test_count;
  int miscompares = 0;
  int checks = 0;
  int div = 0;
  logic [31:0] seed = 32'h1D54;
  // one slow clock feeds every source, so both counters see the same edges
  assign i_first_clocks = {`DCKM_SRC0_N{slow_clk}};
  assign i_second_clocks = {`DCKM_SRC1_N{slow_clk}};
  dckm_dual_clock_checker DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_first_clocks(i_first_clocks), .i_second_clocks(i_second_clocks),
    .i_first_counter_source_select(i_first_counter_source_select),
    .i_second_counter_source_select(i_second_counter_source_select),
    .i_ref_seed(i_ref_seed), .i_tol_window(i_tol_window), .i_test_seed(i_test_seed),
    .i_enable(i_enable), .i_single_mode(i_single_mode), .i_start(i_start),
    .i_clear_flags(i_clear_flags), .o_busy(o_busy), .o_done(o_done), .o_error(o_error),
    .o_error_event(o_error_event), .o_ref_count(o_ref_count), .o_test_count(o_test_count));
  always #10 i_clk = ~i_clk;
  // period of six system cycles keeps the source well under half the clock
  always @(posedge i_clk) begin
    #1;
    div = (div == 2) ? 0 : div + 1;
    if (div == 0) slow_clk = ~slow_clk;
  end
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // pass if test ends no later than ref, with what is left of ref inside the window
  function automatic logic expect_pass(input int r, input int t, input int w);
    return (t != 0) && (r + w >= t) && (r <= t);
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_flag(input int limit);
    int n;
    n = 0;
    while (o_done !== 1'b1 && o_error !== 1'b1 && n < limit) begin
      tick();
      n++;
    end
  endtask
  task automatic pulse_clear();
    i_clear_flags = 1'b1;
    tick();
    i_clear_flags = 1'b0;
  endtask
  task automatic run(input int r, input int t, input int w, input logic single);
    logic pass;
    int n;
    pass = expect_pass(r, t, w);
    i_enable = 1'b0;
    tick();
    tick();
    pulse_clear();
    i_ref_seed = r[19:0];
    i_test_seed = t[19:0];
    i_tol_window = w[15:0];
    i_single_mode = single;
    i_enable = 1'b1;
    i_start = 1'b1;
    n = 0;
    while (o_busy !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    i_start = 1'b0;
    check("ref_count", r + w, {11'h000, o_ref_count});
    check("test_count", t, {11'h000, o_test_count});
    wait_flag(500);
    check("done", {31'h0, pass}, {31'h0, o_done});
    check("error", {31'h0, !pass}, {31'h0, o_error});
    check("error_event", {31'h0, !pass}, {31'h0, o_error_event});
    tick();
    check("busy", {31'h0, pass && !single}, {31'h0, o_busy});
    check("error_event", 32'h0, {31'h0, o_error_event});
    check("error_sticky", {31'h0, !pass}, {31'h0, o_error});
  endtask
  initial begin
    #(20 * 40000);
    miscompares++;
    wrap_up();
  end
  initial begin
    int r, t, w;
    repeat (8) tick();
    i_reset_n = 1'b1;
    tick();
    for (int c = 0; c < `DCKM_SRC0_N; c++) begin
      i_first_counter_source_select = c[3:0];
      i_enable = 1'b1;
      tick();
      tick();
      check("busy_sel0", {31'h0, 1'(`DCKM_SRC0_MAP >> c)}, {31'h0, o_busy});
      i_enable = 1'b0;
      tick();
      tick();
    end
    i_first_counter_source_select = `DCKM_S0_CRYSTAL;
    for (int c = 0; c < `DCKM_SRC1_N; c++) begin
      i_second_counter_source_select = c[4:0];
      i_enable = 1'b1;
      tick();
      tick();
      check("busy_sel1", (`DCKM_SRC1_MAP >> c) & 32'h1, {31'h0, o_busy});
      i_enable = 1'b0;
      tick();
      tick();
    end
    check("no_flag", 32'h0, {30'h0, o_done, o_error});
    i_second_counter_source_select = `DCKM_S1_CAN_BIT;
    run(4, 0, 2, 1'b1);
    run(2, 6, 1, 1'b0);
    run(4, 4, 0, 1'b0);
    // continuous pass reloads itself with no start
    pulse_clear();
    wait_flag(500);
    check("restart_done", 32'h1, {31'h0, o_done});
    run(5, 6, 3, 1'b1);
    pulse_clear();
    repeat (150) tick();
    check("single_idle", 32'h0, {30'h0, o_done, o_busy});
    for (int k = 0; k < 8; k++) begin
      r = 1 + int'(rnd() % 8);
      t = 1 + int'(rnd() % 8);
      w = int'(rnd() % 4);
      if (r + w == t) w++;
      run(r, t, w, 1'(rnd()));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
